//--- rtl/prgi_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PRGI_CONSTS_SVH
`define PRGI_CONSTS_SVH

`define PRGI_ADDR_W          8
`define PRGI_OFS_PWR_CTRL    8'h0_1
`define PRGI_OFS_IRQ_SUM     8'h0_2
`define PRGI_OFS_IRQ_STAT    8'h0_4
`define PRGI_OFS_IRQ_MASK    8'h0_5
`define PRGI_BIT_CONV        0
`define PRGI_BIT_RX          1
`define PRGI_BIT_TX          2
`define PRGI_BIT_PB          3
`define PRGI_BIT_PA          4
`define PRGI_BIT_ALL         5
`define PRGI_BIT_RESET       7
`define PRGI_PWR_RST_VAL     8'h0_0
`define PRGI_PWR_WR_MASK     8'h3_F
`define PRGI_MASK_RST_VAL    8'h0_0
`define PRGI_SRC_CNT_W       3
`define PRGI_RESET_NS        64
`define PRGI_CLK_NS          8
`define PRGI_RESET_CYC       ((`PRGI_RESET_NS + `PRGI_CLK_NS - 1) / `PRGI_CLK_NS)

`endif

//--- rtl/prgi_irq_sum.sv
// Per-block interrupt summary: OR of unmasked active source flags
`timescale 1ns/1ps
`default_nettype none
module prgi_irq_sum (
  input  wire logic [7:0] i_conv_flags,
  input  wire logic [7:0] i_conv_mask,
  input  wire logic [7:0] i_rx_flags,
  input  wire logic [7:0] i_rx_mask,
  input  wire logic [7:0] i_tx_flags,
  input  wire logic [7:0] i_tx_mask,
  output logic [2:0]      o_sum
);
  function automatic logic any_active(input logic [7:0] f,
                                      input logic [7:0] m);
    any_active = |(f & m);
  endfunction

  // ==========================================================
  // Summary bits
  assign o_sum[0] = any_active(i_conv_flags, i_conv_mask);
  assign o_sum[1] = any_active(i_rx_flags, i_rx_mask);
  assign o_sum[2] = any_active(i_tx_flags, i_tx_mask);
endmodule // prgi_irq_sum
`default_nettype wire

//--- rtl/prgi_pkg.sv
// Types shared by the power, reset and interrupt summary block
package prgi_pkg;
  typedef enum logic [2:0] {
    PRGI_RUN   = 3'b001,
    PRGI_HOLD  = 3'b010,
    PRGI_DONE  = 3'b100
  } prgi_rst_state_t;
endpackage

//--- rtl/prgi_rst_seq.sv
// Reset sequencer: stretches a reset request into a fixed init pulse
`timescale 1ns/1ps
`default_nettype none
`include "prgi_consts.svh"
module prgi_rst_seq (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_req,
  output logic      o_init,
  output logic      o_done
);
  prgi_pkg::prgi_rst_state_t state_ff;
  prgi_pkg::prgi_rst_state_t nxt_state;
  logic [`PRGI_SRC_CNT_W-1:0] cnt_ff;
  logic [`PRGI_SRC_CNT_W-1:0] nxt_cnt;
  localparam logic [`PRGI_SRC_CNT_W-1:0] LAST =
    `PRGI_SRC_CNT_W'(`PRGI_RESET_CYC - 1);

  // ==========================================================
  // Sequence control
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      prgi_pkg::PRGI_RUN: begin
        if (i_req) begin
          nxt_state = prgi_pkg::PRGI_HOLD;
          nxt_cnt   = '0;
        end
      end
      prgi_pkg::PRGI_HOLD: begin
        if (cnt_ff == LAST) begin
          nxt_state = prgi_pkg::PRGI_DONE;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      prgi_pkg::PRGI_DONE: begin
        nxt_state = prgi_pkg::PRGI_RUN;
      end
      default: begin
        nxt_state = prgi_pkg::PRGI_RUN;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= prgi_pkg::PRGI_RUN;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign o_init = (state_ff == prgi_pkg::PRGI_HOLD);
  assign o_done = (state_ff == prgi_pkg::PRGI_DONE);
endmodule // prgi_rst_seq
`default_nettype wire

//--- rtl/prgi_top.sv
// Power-down, software reset and global interrupt summary block
// How it works
// - Converter sleep bit 0 holds converter powered down; 1 runs it.
// - Receiver sleep bit 0 powers receiver down, its outputs low.
// - Port B sleep bit 0 powers port B down, outputs forced low.
// - Port A sleep bit 0 powers port A down, outputs forced low.
// - All-blocks sleep bit 0 powers down every block but host, registers.
// - Writing 1 to reset bit holds o_blk_rst high for 8 cycles; external reset does not.
// - Software reset returns all control registers to defaults.
// - Summary bit 0 shows converter interrupt active.
// - Summary bit 1 shows receiver interrupt active.
// - Summary bit 2 shows transmitter interrupt active.
// - Summary read-only; its bits 7..3 and control bit 6 read zero.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "prgi_consts.svh"
module prgi_top (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  input  wire logic [7:0] i_conv_flags,
  input  wire logic [7:0] i_conv_mask,
  input  wire logic [7:0] i_rx_flags,
  input  wire logic [7:0] i_rx_mask,
  input  wire logic [7:0] i_tx_flags,
  input  wire logic [7:0] i_tx_mask,
  input  wire logic [3:0] i_rx_outs,
  input  wire logic [3:0] i_tx_outs,
  input  wire logic [3:0] i_pa_outs,
  input  wire logic [3:0] i_pb_outs,
  output logic            o_conv_run,
  output logic            o_rx_run,
  output logic            o_tx_run,
  output logic            o_pa_run,
  output logic            o_pb_run,
  output logic [3:0]      o_rx_outs,
  output logic [3:0]      o_tx_outs,
  output logic [3:0]      o_pa_outs,
  output logic [3:0]      o_pb_outs,
  output logic            o_blk_rst,
  output logic            o_irq
);
  logic [7:0] pwr_ff;
  logic [7:0] nxt_pwr;
  logic [7:0] stat_ff;
  logic [7:0] nxt_stat;
  logic [7:0] mask_ff;
  logic [7:0] nxt_mask;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [2:0] sum;
  logic [2:0] sum_q_ff;
  logic [2:0] nxt_sum_q;
  logic       init;
  logic       done;
  logic       all_on;

  // ==========================================================
  // Submodules
  prgi_irq_sum u_sum (
    .i_conv_flags (i_conv_flags),
    .i_conv_mask  (i_conv_mask),
    .i_rx_flags   (i_rx_flags),
    .i_rx_mask    (i_rx_mask),
    .i_tx_flags   (i_tx_flags),
    .i_tx_mask    (i_tx_mask),
    .o_sum        (sum)
  );

  prgi_rst_seq u_seq (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_req  (pwr_ff[`PRGI_BIT_RESET]),
    .o_init (init),
    .o_done (done)
  );

  // ==========================================================
  // Register file
  always_comb begin
    nxt_pwr   = pwr_ff;
    nxt_mask  = mask_ff;
    nxt_rdata = 8'h0_0;
    nxt_sum_q = sum;
    // Rising summary bits latch sticky status; set wins over clear
    nxt_stat  = stat_ff;
    if (i_wr && i_addr == `PRGI_OFS_IRQ_STAT) begin
      nxt_stat = stat_ff & ~i_wdata;
    end
    nxt_stat[2:0] = nxt_stat[2:0] | (sum & ~sum_q_ff);
    if (i_wr && i_addr == `PRGI_OFS_PWR_CTRL) begin
      nxt_pwr = i_wdata & (`PRGI_PWR_WR_MASK | 8'h8_0);
    end
    if (i_wr && i_addr == `PRGI_OFS_IRQ_MASK) begin
      nxt_mask = i_wdata & 8'h0_7;
    end
    if (done) begin
      nxt_pwr  = `PRGI_PWR_RST_VAL;
      nxt_mask = `PRGI_MASK_RST_VAL;
      nxt_stat = 8'h0_0;
    end
    if (i_rd) begin
      case (i_addr)
        `PRGI_OFS_PWR_CTRL: nxt_rdata = pwr_ff;
        `PRGI_OFS_IRQ_SUM: begin
          nxt_rdata = {5'h0_0, sum};
        end
        `PRGI_OFS_IRQ_STAT: nxt_rdata = stat_ff;
        `PRGI_OFS_IRQ_MASK: nxt_rdata = mask_ff;
        default:            nxt_rdata = 8'h0_0;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pwr_ff   <= `PRGI_PWR_RST_VAL;
      mask_ff  <= `PRGI_MASK_RST_VAL;
      stat_ff  <= 8'h0_0;
      rdata_ff <= 8'h0_0;
      sum_q_ff <= 3'h0;
    end else begin
      pwr_ff   <= nxt_pwr;
      mask_ff  <= nxt_mask;
      stat_ff  <= nxt_stat;
      rdata_ff <= nxt_rdata;
      sum_q_ff <= nxt_sum_q;
    end
  end

  // ==========================================================
  // Power gating
  assign all_on     = pwr_ff[`PRGI_BIT_ALL] & ~init;
  assign o_conv_run = all_on & pwr_ff[`PRGI_BIT_CONV];
  assign o_rx_run   = all_on & pwr_ff[`PRGI_BIT_RX];
  assign o_tx_run   = all_on & pwr_ff[`PRGI_BIT_TX];
  assign o_pb_run   = all_on & pwr_ff[`PRGI_BIT_PB];
  assign o_pa_run   = all_on & pwr_ff[`PRGI_BIT_PA];
  assign o_rx_outs  = i_rx_outs & {4{o_rx_run}};
  assign o_tx_outs  = i_tx_outs & {4{o_tx_run}};
  assign o_pb_outs  = i_pb_outs & {4{o_pb_run}};
  assign o_pa_outs  = i_pa_outs & {4{o_pa_run}};
  assign o_blk_rst  = init;
  assign o_rdata    = rdata_ff;
  assign o_irq      = |(stat_ff & mask_ff);
endmodule // prgi_top
`default_nettype wire

//--- tb/prgi_monitor.sv
// Assertion checker for the power, reset and irq summary block
`timescale 1ns/1ps
`default_nettype none
module prgi_monitor (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [3:0] i_rx_outs,
  input wire logic [3:0] i_tx_outs,
  input wire logic [3:0] i_pa_outs,
  input wire logic [3:0] i_pb_outs,
  input wire logic [3:0] o_rx_outs,
  input wire logic [3:0] o_tx_outs,
  input wire logic [3:0] o_pa_outs,
  input wire logic [3:0] o_pb_outs,
  input wire logic       o_conv_run,
  input wire logic       o_rx_run,
  input wire logic       o_tx_run,
  input wire logic       o_pa_run,
  input wire logic       o_pb_run,
  input wire logic       o_blk_rst
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ==========================================
  // Output gating, reset sequence and read data
  a_rx_gate:
    assert property (o_rx_outs == (i_rx_outs & {4{o_rx_run}}))
    else $error("rx outputs not gated");
  a_tx_gate:
    assert property (o_tx_outs == (i_tx_outs & {4{o_tx_run}}))
    else $error("tx outputs not gated");
  a_pb_gate:
    assert property (o_pb_outs == (i_pb_outs & {4{o_pb_run}}))
    else $error("port b outputs not gated");
  a_pa_gate:
    assert property (o_pa_outs == (i_pa_outs & {4{o_pa_run}}))
    else $error("port a outputs not gated");
  a_sleep_in_rst:
    assert property (o_blk_rst |-> !(o_conv_run || o_rx_run || o_tx_run
      || o_pa_run || o_pb_run)) else $error("block runs during reset");
  a_rst_start:
    assert property (i_wr && i_addr == 8'h0_1 && i_wdata[7] |-> ##[1:2]
      o_blk_rst) else $error("software reset not started");
  a_rst_len:
    assert property ($rose(o_blk_rst) |-> o_blk_rst[*8] ##1 !o_blk_rst)
    else $error("reset sequence length wrong");
  a_rdata_idle:
    assert property (!$past(i_rd) |-> o_rdata == 8'h0_0)
    else $error("read data outside read cycle");
  a_sum_zero:
    assert property ($past(i_rd) && $past(i_addr) == 8'h0_2
      |-> o_rdata[7:3] == 5'h0_0) else $error("summary high bits set");
  a_ctl_bit6:
    assert property ($past(i_rd) && $past(i_addr) == 8'h0_1
      |-> !o_rdata[6]) else $error("control bit 6 set");
endmodule // prgi_monitor
bind prgi_top prgi_monitor mon_u (.*);
`default_nettype wire

//--- tb/prgi_top_tb.sv
// Self-checking testbench for the power, reset and irq summary block
`timescale 1ns/1ps
`default_nettype none
module prgi_top_tb;
  logic       i_mclk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = '0, i_wdata = '0, o_rdata;
  logic [7:0] i_conv_flags = '0, i_conv_mask = '0, i_rx_flags = '0;
  logic [7:0] i_rx_mask = '0, i_tx_flags = '0, i_tx_mask = '0;
  logic [3:0] i_rx_outs = 4'hF, i_tx_outs = 4'hF, i_pa_outs = 4'hF;
  logic [3:0] i_pb_outs = 4'hF, o_rx_outs, o_tx_outs, o_pa_outs, o_pb_outs;
  logic       o_conv_run, o_rx_run, o_tx_run, o_pa_run, o_pb_run;
  logic       o_blk_rst, o_irq;
  logic [7:0] runs;
  int         miscompares = 0, n_tests = 0;
  assign runs = {3'h0, o_pa_run, o_pb_run, o_tx_run, o_rx_run, o_conv_run};
  always #4 i_mclk = ~i_mclk;
  prgi_top dut_u (.*);
  // ==========================================
  // Bus tasks
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("BAD %s exp %h got %h", nm, exp, seen);
      miscompares++;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_mclk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(string nm, logic [7:0] a, logic [7:0] exp);
    @(posedge i_mclk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(nm, o_rdata, exp);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    #20_000;
    miscompares++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    chk("runs rst", runs, 8'h0_0);
    chk("outs rst", {o_rx_outs, o_tx_outs}, 8'h0_0);
    chk("ports rst", {o_pa_outs, o_pb_outs}, 8'h0_0);
    rd("ctl rst", 8'h0_1, 8'h0_0);
    for (int i = 0; i < 5; i++) begin
      wr(8'h0_1, 8'h2_0 | (8'h0_1 << i));
      chk("run one", runs, 8'h0_1 << i);
    end
    wr(8'h0_1, 8'h7_F);
    chk("outs on", {o_rx_outs, o_tx_outs}, 8'hF_F);
    chk("ports on", {o_pa_outs, o_pb_outs}, 8'hF_F);
    rd("ctl b6", 8'h0_1, 8'h3_F);
    wr(8'h0_1, 8'h1_F);
    chk("all off", runs, 8'h0_0);
    $display("test power done");
    @(posedge i_mclk);
    {i_conv_flags, i_conv_mask, i_rx_flags} <= {8'h1_0, 8'h1_0, 8'h0_1};
    {i_tx_flags, i_tx_mask} <= {8'h8_0, 8'h8_0};
    rd("sum", 8'h0_2, 8'h0_5);
    wr(8'h0_2, 8'hF_F);
    rd("sum ro", 8'h0_2, 8'h0_5);
    @(posedge i_mclk);
    i_rx_mask <= 8'h0_1;
    rd("sum rx", 8'h0_2, 8'h0_7);
    chk("irq masked", {7'h0, o_irq}, 8'h0_0);
    wr(8'h0_5, 8'h0_7);
    chk("irq on", {7'h0, o_irq}, 8'h0_1);
    @(posedge i_mclk);
    {i_conv_flags, i_rx_flags, i_tx_flags} <= 24'h00_0000;
    rd("sum clr", 8'h0_2, 8'h0_0);
    rd("sticky", 8'h0_4, 8'h0_7);
    wr(8'h0_4, 8'h0_7);
    chk("irq clr", {7'h0, o_irq}, 8'h0_0);
    $display("test irq done");
    wr(8'h0_1, 8'hB_F);
    for (int k = 0; k < 4 && !o_blk_rst; k++) @(posedge i_mclk);
    #1;
    chk("blk rst", {runs[6:0], o_blk_rst}, 8'h0_1);
    for (int k = 0; k < 20 && o_blk_rst; k++) @(posedge i_mclk);
    repeat (2) @(posedge i_mclk);
    rd("ctl sw", 8'h0_1, 8'h0_0);
    rd("mask sw", 8'h0_5, 8'h0_0);
    rd("unmapped", 8'h7_E, 8'h0_0);
    wr(8'h0_1, 8'h3_F);
    chk("runs pre", runs, 8'h1_F);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    chk("runs ext", runs, 8'h0_0);
    rd("ctl ext", 8'h0_1, 8'h0_0);
    $display("test reset done");
    test_done();
  end
endmodule // prgi_top_tb
`default_nettype wire
